// ### verilog/trace_user_record_and_bkpt_trigger.sv
/*
  User trace payload register and breakpoint trigger control register,
  with the user record path toward the trace control block.
  Assumes software accesses arrive as one-cycle strobes in the core clock
  domain and the trace master control fields come in as plain levels.
*/
`timescale 1ns/10ps
`default_nettype none
module trace_user_record_and_bkpt_trigger #(
  parameter bit HAS_TRACE = 1'b1,
  parameter bit HAS_BKPT = 1'b1
) (
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic [2:0] regSelect,
  input wire logic [31:0] regWdata,
  output logic [31:0] regRdata,
  input wire logic traceMasterEnable,
  input wire logic userRecordTypeSelect,
  input wire logic [trace_user_pkg::NUM_IBKPT-1:0] instrBkptHit,
  input wire logic [trace_user_pkg::NUM_DBKPT-1:0] dataBkptHit,
  output logic traceStart,
  output logic traceStop,
  output logic userRecordValid,
  input wire logic userRecordReady,
  output logic userRecordType,
  output logic [31:0] userRecordPayload,
  output logic userRecordDropped
);
  import trace_user_pkg::*;

  // ************************************************************
  // State
  // ************************************************************
  typedef struct packed {
    logic [31:0] payload;
    logic [31:0] trigger;
    logic [31:0] rdata;
    logic start;
    logic stop;
    logic dropped;
  } core_state_t;

  core_state_t state;
  core_state_t next_state;
  logic payloadWrite;
  logic triggerWrite;
  logic recordPush;
  logic recordReady;
  logic [32:0] recordIn;
  logic [32:0] recordOut;
  logic [NUM_IBKPT-1:0] instrGated;
  logic [NUM_DBKPT-1:0] dataGated;
  logic [NUM_IBKPT-1:0] instrStartEn;
  logic [NUM_DBKPT-1:0] dataStartEn;

  // ************************************************************
  // Register select decode
  // ************************************************************
  // Write and read share one decode, so a build option that leaves a
  // register out removes it from both paths at once.
  // payload needs trace
  function automatic logic payloadSelected(input logic [2:0] sel);
    return HAS_TRACE && (sel == SEL_USER_PAYLOAD);
  endfunction

  function automatic logic triggerSelected(input logic [2:0] sel);
    return HAS_TRACE && HAS_BKPT && (sel == SEL_BKPT_TRIGGER);
  endfunction

  // Each register exists only when its build options are present.
  assign payloadWrite = regWrite && payloadSelected(regSelect);
  assign triggerWrite = regWrite && triggerSelected(regSelect);

  assign recordPush = payloadWrite && traceMasterEnable;

  assign recordIn = {userRecordTypeSelect, regWdata};

  assign instrStartEn = state.trigger[NUM_IBKPT-1:0];
  assign dataStartEn = state.trigger[DATA_START_LSB +: NUM_DBKPT];

  assign instrGated = instrBkptHit &
    {NUM_IBKPT{state.trigger[INSTR_GATE_BIT]}};
  assign dataGated = dataBkptHit & {NUM_DBKPT{state.trigger[DATA_GATE_BIT]}};

  // ************************************************************
  // Register update and trigger decode
  // ************************************************************
  always_comb begin
    next_state = state;
    if (payloadWrite) begin
      next_state.payload = regWdata;
    end
    if (triggerWrite) begin
      next_state.trigger = regWdata & TRIGGER_WRITE_MASK;
    end
    // Read data is registered so the read port stays glitch free.
    next_state.rdata = 32'h00000000;
    if (regRead) begin
      if (payloadSelected(regSelect)) begin
        next_state.rdata = state.payload;
      end else if (triggerSelected(regSelect)) begin
        next_state.rdata = state.trigger;
      end
    end
    // gated breakpoints start or stop tracing
    // per-breakpoint start enable
    // A gated trigger without its start enable is taken as a stop.
    next_state.start = traceMasterEnable &&
      (|(instrGated & instrStartEn) || |(dataGated & dataStartEn));
    next_state.stop = traceMasterEnable &&
      (|(instrGated & ~instrStartEn) || |(dataGated & ~dataStartEn));
    // Sticky until reset: a refused record is a trace-loss event.
    next_state.dropped = state.dropped || (recordPush && !recordReady);
  end

  // Register the whole state in one place.
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      state <= '0;
      state.payload <= PAYLOAD_RESET;
      state.trigger <= TRIGGER_RESET;
    end else begin
      state <= next_state;
    end
  end

  // ************************************************************
  // Record path
  // ************************************************************
  // one record per payload write while the master trace enable is set
  trace_skid_buffer #(
    .WIDTH(33)
  ) u_buffer (
    .clk_sys(clk_sys),
    .srst(srst),
    .inValid(recordPush),
    .inReady(recordReady),
    .inData(recordIn),
    .outValid(userRecordValid),
    .outReady(userRecordReady),
    .outData(recordOut)
  );

  assign userRecordType = recordOut[32];
  assign userRecordPayload = recordOut[31:0];
  assign regRdata = state.rdata;
  assign traceStart = state.start;
  assign traceStop = state.stop;
  assign userRecordDropped = state.dropped;

  // ************************************************************
  // Checks
  // ************************************************************
  property p_record_per_write;
    @(posedge clk_sys) disable iff (srst)
    (recordPush && recordReady) |=> userRecordValid;
  endproperty
  a_record_per_write: assert property (p_record_per_write)
    else $error("Accepted user write produced no record.");

  property p_type_follows_select;
    @(posedge clk_sys) disable iff (srst)
    (recordPush && recordReady && !userRecordValid) |=>
      (userRecordType == $past(userRecordTypeSelect));
  endproperty
  a_type_follows_select: assert property (p_type_follows_select)
    else $error("Record type does not match type select.");

  property p_type2_code;
    @(posedge clk_sys) disable iff (srst)
    (recordPush && recordReady && !userRecordValid && userRecordTypeSelect)
      |=> (userRecordType == 1'b1);
  endproperty
  a_type2_code: assert property (p_type2_code)
    else $error("Type select one did not give type two.");

  property p_payload_stored;
    @(posedge clk_sys) disable iff (srst)
    payloadWrite |=> (state.payload == $past(regWdata));
  endproperty
  a_payload_stored: assert property (p_payload_stored)
    else $error("Payload register did not take written value.");

  property p_payload_carried;
    @(posedge clk_sys) disable iff (srst)
    (recordPush && recordReady && !userRecordValid) |=>
      (userRecordPayload == $past(regWdata));
  endproperty
  a_payload_carried: assert property (p_payload_carried)
    else $error("Record payload differs from written data.");

  property p_reserved_zero;
    @(posedge clk_sys) disable iff (srst)
    triggerWrite |=> (state.trigger[14:6] == 9'h000);
  endproperty
  a_reserved_zero: assert property (p_reserved_zero)
    else $error("Unimplemented trigger bits are not zero.");

  property p_no_output_when_off;
    @(posedge clk_sys) disable iff (srst)
    !traceMasterEnable |=> !traceStart && !traceStop;
  endproperty
  a_no_output_when_off: assert property (p_no_output_when_off)
    else $error("Trigger fired with master enable off.");

  property p_instr_gate;
    @(posedge clk_sys) disable iff (srst)
    (!state.trigger[INSTR_GATE_BIT] && !state.trigger[DATA_GATE_BIT])
      |=> !traceStart;
  endproperty
  a_instr_gate: assert property (p_instr_gate)
    else $error("Start fired with both gates closed.");

  property p_data_start;
    @(posedge clk_sys) disable iff (srst)
    (traceMasterEnable && state.trigger[DATA_GATE_BIT] &&
      (|(dataBkptHit & dataStartEn))) |=> traceStart;
  endproperty
  a_data_start: assert property (p_data_start)
    else $error("Enabled data breakpoint did not start trace.");

  property p_instr_start;
    @(posedge clk_sys) disable iff (srst)
    (traceMasterEnable && state.trigger[INSTR_GATE_BIT] &&
      (|(instrBkptHit & instrStartEn))) |=> traceStart;
  endproperty
  a_instr_start: assert property (p_instr_start)
    else $error("Enabled instruction breakpoint did not start trace.");

  // A gated hit whose start enable is clear asks for a stop instead.
  property p_instr_stop;
    @(posedge clk_sys) disable iff (srst)
    (traceMasterEnable && state.trigger[INSTR_GATE_BIT] &&
      (|(instrBkptHit & ~instrStartEn))) |=> traceStop;
  endproperty
  a_instr_stop: assert property (p_instr_stop)
    else $error("Unenabled instruction hit did not stop trace.");

  property p_data_stop;
    @(posedge clk_sys) disable iff (srst)
    (traceMasterEnable && state.trigger[DATA_GATE_BIT] &&
      (|(dataBkptHit & ~dataStartEn))) |=> traceStop;
  endproperty
  a_data_stop: assert property (p_data_stop)
    else $error("Unenabled data hit did not stop trace.");

  // With one gate closed and the other source idle, nothing may fire.
  property p_data_blocked;
    @(posedge clk_sys) disable iff (srst)
    (!state.trigger[DATA_GATE_BIT] && !(|instrBkptHit)) |=>
      (!traceStart && !traceStop);
  endproperty
  a_data_blocked: assert property (p_data_blocked)
    else $error("Data hit passed a closed data gate.");

  property p_instr_blocked;
    @(posedge clk_sys) disable iff (srst)
    (!state.trigger[INSTR_GATE_BIT] && !(|dataBkptHit)) |=>
      (!traceStart && !traceStop);
  endproperty
  a_instr_blocked: assert property (p_instr_blocked)
    else $error("Instruction hit passed a closed instruction gate.");

  property p_read_payload;
    @(posedge clk_sys) disable iff (srst)
    (regRead && payloadSelected(regSelect)) |=>
      (regRdata == $past(state.payload));
  endproperty
  a_read_payload: assert property (p_read_payload)
    else $error("Payload read returned the wrong value.");

  property p_read_reserved;
    @(posedge clk_sys) disable iff (srst)
    (regRead && triggerSelected(regSelect)) |=>
      (regRdata[14:6] == 9'h000);
  endproperty
  a_read_reserved: assert property (p_read_reserved)
    else $error("Unimplemented trigger bits read as nonzero.");

  // A refused write must not slip a record into an empty buffer.
  property p_no_record_when_off;
    @(posedge clk_sys) disable iff (srst)
    (payloadWrite && !traceMasterEnable && !userRecordValid) |=>
      !userRecordValid;
  endproperty
  a_no_record_when_off: assert property (p_no_record_when_off)
    else $error("Record emitted with master enable off.");

  c_record: cover property (@(posedge clk_sys) recordPush ##1 userRecordValid);
  c_drop: cover property (@(posedge clk_sys) $rose(userRecordDropped));
  c_stall: cover property (@(posedge clk_sys) userRecordValid && !userRecordReady
    ##1 recordPush ##2 !recordReady);
  c_start: cover property (@(posedge clk_sys) traceStart);
  c_stop: cover property (@(posedge clk_sys) traceStop);

endmodule
`default_nettype wire

// ### verilog/trace_user_pkg.sv
/*
  Constants, field positions and reset values for the user trace record
  and breakpoint trigger control block.
  Assumes a single core clock domain and a coprocessor-style register port.
*/
// Summary of operation
// - Each payload register write with master trace enable set emits one user record; one that meets a full record buffer is lost and sets userRecordDropped.
// - Each user record is tagged user type 1 or user type 2.
// - Type select is trace control bit 30; one means type 2.
// - Payload register is 32-bit read/write, resets to zero, carried in record.
// - Payload register exists only when trace capability is built in.
// - Trigger control lets chosen hardware breakpoints start and stop tracing.
// - Trigger control exists only with breakpoints and trace both built in.
// - Bit 31 gates data breakpoint triggers; resets to zero.
// - Bit 15 gates instruction breakpoint triggers; resets to zero.
// - Bits 5..0 let instruction breakpoints 6..1 start tracing.
// - Bits 14..6 read as zero and ignore writes.
// - Nothing produces trace output unless the master trace enable is set.
package trace_user_pkg;

  // ************************************************************
  // Register selects on the coprocessor port
  // ************************************************************
  localparam logic [2:0] SEL_USER_PAYLOAD = 3'h3;
  localparam logic [2:0] SEL_BKPT_TRIGGER = 3'h4;

  // ************************************************************
  // Field positions and reset values
  // ************************************************************
  localparam int TYPE_SELECT_BIT = 30;
  localparam int DATA_GATE_BIT = 31;
  localparam int INSTR_GATE_BIT = 15;
  localparam int DATA_START_LSB = 16;
  localparam int NUM_IBKPT = 6;
  localparam int NUM_DBKPT = 2;
  localparam logic [31:0] TRIGGER_WRITE_MASK = 32'h8003803f;
  localparam logic [31:0] PAYLOAD_RESET = 32'h00000000;
  localparam logic [31:0] TRIGGER_RESET = 32'h00000000;

  // Record type codes on the trace output port.
  typedef enum logic {
    USER_TYPE1,
    USER_TYPE2
  } user_type_t;

endpackage

// ### verilog/trace_skid_buffer.sv
/*
  Two-entry valid/ready buffer for trace records.
  Assumes source and sink share clk_sys and srst.
*/
`timescale 1ns/10ps
`default_nettype none
module trace_skid_buffer #(
  parameter int WIDTH = 33
) (
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic inValid,
  output logic inReady,
  input wire logic [WIDTH-1:0] inData,
  output logic outValid,
  input wire logic outReady,
  output logic [WIDTH-1:0] outData
);

  // ************************************************************
  // State
  // ************************************************************
  typedef struct packed {
    logic [1:0][WIDTH-1:0] slot;
    logic [1:0] count;
  } buf_state_t;

  buf_state_t state;
  buf_state_t next_state;
  logic push;
  logic pop;

  // Two slots: slot 0 is the head, so the output is always a flop.
  always_comb begin
    next_state = state;
    push = inValid && inReady;
    pop = outValid && outReady;
    if (pop) begin
      next_state.slot[0] = state.slot[1];
      next_state.count = state.count - 2'h1;
    end
    if (push) begin
      if (next_state.count == 2'h0) begin
        next_state.slot[0] = inData;
      end else begin
        next_state.slot[1] = inData;
      end
      next_state.count = next_state.count + 2'h1;
    end
  end

  // Register the whole state in one place.
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign inReady = (state.count != 2'h2);
  assign outValid = (state.count != 2'h0);
  assign outData = state.slot[0];

endmodule
`default_nettype wire

// ### testbench/trace_sink_model.sv
/*
  Behavioural sink that stands in for the trace control block.
  Assumes it shares clk_sys and srst with the block under test.
*/
`timescale 1ns/10ps
`default_nettype none
module trace_sink_model (
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic holdOff,
  output logic userRecordReady
);
  logic [1:0] phase;

  // Free running phase; the sink stalls one cycle in four so the buffer
  // always sees some back-pressure, even in the plain scenarios.
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      phase <= 2'h0;
    end else begin
      phase <= phase + 2'h1;
    end
  end

  // The bench may also stall the sink outright to fill the buffer.
  assign userRecordReady = !holdOff && (phase != 2'h3);
endmodule
`default_nettype wire

// ### testbench/trace_user_record_and_bkpt_trigger_tb.sv
/*
  Self-checking bench for the user record and trigger control block.
  Assumes the sink model file is compiled before this one.
*/
`timescale 1ns/10ps
`default_nettype none
module trace_user_record_and_bkpt_trigger_tb;
  import trace_user_pkg::*;
  logic clk_sys = 1'b0;
  logic srst = 1'b1;
  logic regWrite = 1'b0;
  logic regRead = 1'b0;
  logic [2:0] regSelect = 3'h0;
  logic [31:0] regWdata = 32'h0;
  logic [31:0] regRdata;
  logic traceMasterEnable = 1'b0;
  logic userRecordTypeSelect = 1'b0;
  logic [5:0] instrBkptHit = 6'h0;
  logic [1:0] dataBkptHit = 2'h0;
  logic traceStart, traceStop, userRecordValid, userRecordReady;
  logic userRecordType, userRecordDropped;
  logic [31:0] userRecordPayload;
  logic holdOff = 1'b0;
  logic [32:0] expQ[$];
  logic [31:0] trigReg = 32'h0;
  logic [31:0] d;
  logic [1:0] expTrig = 2'h0;
  int bad_count = 0;
  int cmp_count = 0;
  int seed = 32'h416a;

  always #20 clk_sys = ~clk_sys;

  trace_user_record_and_bkpt_trigger trace_user_record_and_bkpt_trigger_i (
    .clk_sys(clk_sys), .srst(srst), .regWrite(regWrite), .regRead(regRead),
    .regSelect(regSelect), .regWdata(regWdata), .regRdata(regRdata),
    .traceMasterEnable(traceMasterEnable),
    .userRecordTypeSelect(userRecordTypeSelect),
    .instrBkptHit(instrBkptHit), .dataBkptHit(dataBkptHit),
    .traceStart(traceStart), .traceStop(traceStop),
    .userRecordValid(userRecordValid), .userRecordReady(userRecordReady),
    .userRecordType(userRecordType), .userRecordPayload(userRecordPayload),
    .userRecordDropped(userRecordDropped));

  trace_sink_model trace_sink_model_i (.clk_sys(clk_sys), .srst(srst),
    .holdOff(holdOff), .userRecordReady(userRecordReady));

  // ************************************************************
  // Checking and closing helpers
  // ************************************************************
  task automatic chk(input logic [32:0] got, input logic [32:0] exp,
                     input string msg);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask

  task automatic summarize;
    $display("Mismatches %0d, comparisons %0d", bad_count, cmp_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // Start and stop requests expected from one cycle of hits.
  function automatic logic [1:0] trigExp(input logic [31:0] r,
      input logic en, input logic [5:0] hi, input logic [1:0] hd);
    logic gi, gd;
    gi = r[15] && en;
    gd = r[31] && en;
    return {(gi && |(hi & r[5:0])) || (gd && |(hd & r[17:16])),
            (gi && |(hi & ~r[5:0])) || (gd && |(hd & ~r[17:16]))};
  endfunction

  // ************************************************************
  // Register port tasks
  // ************************************************************
  // A write holds the strobe for one edge, so back-to-back calls leave a
  // quiet cycle between payload writes.
  task automatic wr(input logic [2:0] s, input logic [31:0] v);
    @(posedge clk_sys);
    regWrite <= 1'b1;
    regSelect <= s;
    regWdata <= v;
    if (s == SEL_USER_PAYLOAD && traceMasterEnable) begin
      expQ.push_back({userRecordTypeSelect, v});
    end
    @(posedge clk_sys);
    regWrite <= 1'b0;
    // Updated after this edge is sampled, like the register itself.
    if (s == SEL_BKPT_TRIGGER) begin
      trigReg <= v & TRIGGER_WRITE_MASK;
    end
  endtask

  task automatic rd(input logic [2:0] s, input logic [31:0] exp);
    @(posedge clk_sys);
    regRead <= 1'b1;
    regSelect <= s;
    @(posedge clk_sys);
    regRead <= 1'b0;
    #1 chk({1'b0, regRdata}, {1'b0, exp}, "read data");
  endtask

  // ************************************************************
  // Monitor: triggers every cycle, records at each handshake
  // ************************************************************
  always @(posedge clk_sys) begin
    if (!srst) begin
      chk({31'h0, traceStart, traceStop}, {31'h0, expTrig}, "trigger");
      if (userRecordValid === 1'b1 && userRecordReady === 1'b1) begin
        if (expQ.size() == 0) begin
          chk(33'h1, 33'h0, "unexpected record");
        end else begin
          chk({userRecordType, userRecordPayload}, expQ.pop_front(), "rec");
        end
      end
    end
    expTrig = trigExp(trigReg, traceMasterEnable, instrBkptHit, dataBkptHit);
  end

  // ************************************************************
  // Main sequence
  // ************************************************************
  initial begin
    repeat (2) @(posedge clk_sys);
    srst <= 1'b0;
    rd(SEL_USER_PAYLOAD, 32'h0);
    rd(SEL_BKPT_TRIGGER, 32'h0);
    wr(SEL_BKPT_TRIGGER, 32'hffffffff);
    rd(SEL_BKPT_TRIGGER, 32'h8003803f);
    wr(3'h5, 32'hffffffff);
    rd(3'h5, 32'h0);
    // Pairs of payload writes two cycles apart; every fourth pair is
    // sent with the master enable off and must leave no record.
    for (int i = 0; i < 20; i++) begin
      @(posedge clk_sys);
      traceMasterEnable <= (i % 4 != 3);
      userRecordTypeSelect <= 1'($random(seed));
      wr(SEL_USER_PAYLOAD, 32'($random(seed)));
      d = 32'($random(seed));
      wr(SEL_USER_PAYLOAD, d);
      rd(SEL_USER_PAYLOAD, d);
      repeat (4) @(posedge clk_sys);
    end
    repeat (10) @(posedge clk_sys);
    chk(33'(expQ.size()), 33'h0, "records lost");
    chk(33'(userRecordDropped), 33'h0, "early drop flag");
    // Random trigger settings, then random hits with the enable toggling.
    for (int k = 0; k < 8; k++) begin
      d = (k == 0) ? 32'hffffffff : 32'($random(seed));
      wr(SEL_BKPT_TRIGGER, d);
      rd(SEL_BKPT_TRIGGER, d & 32'h8003803f);
      repeat (25) begin
        @(posedge clk_sys);
        instrBkptHit <= 6'($random(seed));
        dataBkptHit <= 2'($random(seed));
        traceMasterEnable <= ($random(seed) % 4) != 0;
      end
      @(posedge clk_sys);
      instrBkptHit <= 6'h0;
      dataBkptHit <= 2'h0;
    end
    // Stall the sink: two records fit, the third is lost and flagged.
    @(posedge clk_sys);
    traceMasterEnable <= 1'b1;
    holdOff <= 1'b1;
    for (int j = 0; j < 3; j++) begin
      wr(SEL_USER_PAYLOAD, 32'h5a5a0000 + 32'(j));
    end
    void'(expQ.pop_back());
    repeat (2) @(posedge clk_sys);
    chk(33'(userRecordDropped), 33'h1, "drop flag");
    holdOff <= 1'b0;
    repeat (10) @(posedge clk_sys);
    chk(33'(expQ.size()), 33'h0, "records after stall");
    summarize;
  end

  // A hang is cut short well past the expected run length.
  initial begin
    #200000;
    bad_count++;
    summarize;
  end
endmodule
`default_nettype wire
